// ==== idec_pkg.sv ====
// Shared constants, encodings and carrier structs for the instruction
// execution slice (decrement, increment, skips, clears and branch).
// Assumes a single core clock and a synchronous active-low reset.
package idec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 8;           // File register and W width
  localparam int FADDR_W = 7;           // File address, 0 to 127
  localparam int IMM_W   = 11;          // Branch immediate, 0 to 2047
  localparam int PC_W    = 15;          // Program counter width
  localparam int LATCH_W = 7;           // Page latch register width

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PAGE_MSB = 6;          // Page latch bits feeding PC<14:11>
  localparam int PAGE_LSB = 3;

  // ----------------------------------------------------------------
  // Reset and constant values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] W_RST       = 8'h00;
  localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00; // Written by clear W
  localparam logic [DATA_W-1:0] STEP_ONE    = 8'h01; // Inc/dec step
  localparam logic [PC_W-1:0]   PC_RST      = 15'h0000;
  localparam logic              ZERO_RST    = 1'b0;
  localparam logic              TO_RST      = 1'b1;
  localparam logic              PD_RST      = 1'b1;

  // ----------------------------------------------------------------
  // Operation encoding
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IDEC_NOP_OP               = 3'b000,
    DECREMENT_FILE_OP         = 3'b001,
    CLEAR_WORKING_OP          = 3'b010,
    DECREMENT_SKIP_ZERO_OP    = 3'b011,
    CLEAR_WATCHDOG_OP         = 3'b100,
    ABSOLUTE_BRANCH_OP        = 3'b101,
    INCREMENT_FILE_OP         = 3'b110,
    INCREMENT_SKIP_ZERO_OP    = 3'b111
  } idec_op_t;

  // Sequencer states
  typedef enum logic [0:0] {
    IDEC_ST_EXEC = 1'b0,                // Accepting instructions
    IDEC_ST_SLOT = 1'b1                 // Squashed second cycle
  } idec_state_t;

  // Issued instruction
  typedef struct packed {
    idec_op_t             op;
    logic [FADDR_W-1:0]   faddr;
    logic                 dest;         // 0: W, 1: file register
    logic [IMM_W-1:0]     imm;
  } idec_instr_t;

  // File register write request
  typedef struct packed {
    logic                 we;
    logic [FADDR_W-1:0]   addr;
    logic [DATA_W-1:0]    data;
  } idec_fwrite_t;

endpackage : idec_pkg

// ==== idec_step.sv ====
// Plus or minus one stepper with zero detect, wrapping modulo 2**W.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module idec_step #(
  parameter int W = 8                   // Operand width
) (
  input  wire logic [W-1:0] operand,
  input  wire logic         decrement,
  output logic      [W-1:0] result,
  output logic              is_zero
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (W < 1) begin : g_bad_w
    $error("idec_step: W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Step and zero detect
  // ----------------------------------------------------------------
  wire logic [W-1:0] one_w   = {{(W-1){1'b0}}, 1'b1}; // Step constant
  wire logic [W-1:0] up_w    = operand + one_w;       // Wraps at top
  wire logic [W-1:0] down_w  = operand - one_w;       // Wraps at zero

  assign result  = decrement ? down_w : up_w;
  assign is_zero = (result == '0);

endmodule : idec_step

// ==== idec_core.sv ====
// Execution slice for decrement/increment of a file register, their
// skip-on-zero forms, clear W, clear watchdog and absolute branch.
// Assumes the file read data for instr.faddr is valid with issue_valid,
// and that the watchdog itself sits outside and obeys the clear pulses.
`timescale 1ns/1ps

module idec_core
  import idec_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                issue_valid,     // Instruction offered
  input  wire idec_instr_t         instr,           // Offered instruction
  input  wire logic [DATA_W-1:0]   file_rdata,      // Addressed file value
  input  wire logic [LATCH_W-1:0]  program_page_latch,
  input  wire logic                timeout_event,   // Watchdog expired
  input  wire logic                sleep_event,     // Entering power-down
  output logic                     issue_ready,     // Instruction taken
  output logic [DATA_W-1:0]        w_reg,           // Working register
  output logic                     zero_flag,       // Status zero bit
  output idec_fwrite_t             fwrite,          // File write pulse
  output logic                     pc_load,         // Branch pulse
  output logic [PC_W-1:0]          pc_target,       // Branch address
  output logic                     nop_slot,        // Squashed cycle
  output logic                     watchdog_counter_clear,
  output logic                     watchdog_prescaler_clear,
  output logic                     timeout_status_bit,
  output logic                     power_down_status_bit
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  idec_state_t         state_q, state_d;    // Sequencer
  logic                ready_q, ready_d;    // Mirrors next state
  logic [DATA_W-1:0]   w_q, w_d;            // Working register
  logic                zero_q, zero_d;      // Zero flag
  idec_fwrite_t        fwr_q, fwr_d;        // File write request
  logic                pcl_q, pcl_d;        // PC load pulse
  logic [PC_W-1:0]     pct_q, pct_d;        // PC target hold
  logic                slot_q, slot_d;      // NOP slot marker
  logic                wclr_q, wclr_d;      // Counter clear pulse
  logic                pclr_q, pclr_d;      // Prescaler clear pulse
  logic                to_q, to_d;          // Timeout status
  logic                pd_q, pd_d;          // Power-down status

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic accept    = issue_valid & ready_q;           // Taken this edge
  wire logic op_dec    = (instr.op == DECREMENT_FILE_OP);
  wire logic op_decsz  = (instr.op == DECREMENT_SKIP_ZERO_OP);
  wire logic op_inc    = (instr.op == INCREMENT_FILE_OP);
  wire logic op_incsz  = (instr.op == INCREMENT_SKIP_ZERO_OP);
  wire logic op_clear_working_op   = (instr.op == CLEAR_WORKING_OP);
  wire logic op_clear_watchdog_op = (instr.op == CLEAR_WATCHDOG_OP);
  wire logic op_branch = (instr.op == ABSOLUTE_BRANCH_OP);
  wire logic is_decr   = op_dec | op_decsz;
  wire logic is_arith  = is_decr | op_inc | op_incsz;
  wire logic is_skipop = op_decsz | op_incsz;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] step_result;           // File value plus or minus one
  logic              step_zero;             // Stepped result equals zero

  // One shared stepper; inc and dec never issue together
  idec_step #(
    .W         (DATA_W)
  ) i_idec_step (
    .operand   (file_rdata),
    .decrement (is_decr),
    .result    (step_result),
    .is_zero   (step_zero)
  );

  // ----------------------------------------------------------------
  // Control terms
  // ----------------------------------------------------------------
  wire logic do_arith  = accept & is_arith;
  wire logic to_w      = do_arith & ~instr.dest;          // Destination 0
  wire logic to_file   = do_arith & instr.dest;           // Destination 1
  wire logic do_skip   = accept & is_skipop & step_zero;
  wire logic do_branch = accept & op_branch;
  wire logic do_wdt    = accept & op_clear_watchdog_op;
  wire logic zero_upd  = accept & (op_dec | op_inc);

  // Page bits 6:3 fill PC<14:11>; full 11-bit immediate fills PC<10:0>
  wire logic [PC_W-1:0] branch_target =
    {program_page_latch[PAGE_MSB:PAGE_LSB], instr.imm};

  // ----------------------------------------------------------------
  // Sequencer: a skip or branch costs one squashed cycle
  // ----------------------------------------------------------------
  always_comb begin
    case (state_q)
      IDEC_ST_EXEC: begin
        state_d = (do_skip | do_branch) ? IDEC_ST_SLOT : IDEC_ST_EXEC;
      end
      IDEC_ST_SLOT: begin
        state_d = IDEC_ST_EXEC;             // Fetched word dropped
      end
      default: begin
        state_d = IDEC_ST_EXEC;
      end
    endcase
  end

  // Ready follows next state so the output stays a flop
  assign ready_d = (state_d == IDEC_ST_EXEC);
  assign slot_d  = do_skip | do_branch;

  // ----------------------------------------------------------------
  // Working register and zero flag
  // ----------------------------------------------------------------
  assign w_d = op_clear_working_op & accept ? CLEAR_VALUE :
               to_w             ? step_result :
                                  w_q;
  // Skip forms never touch the flag, only plain inc/dec and clear W
  assign zero_d = op_clear_working_op & accept ? 1'b1 :
                  zero_upd         ? step_zero :
                                     zero_q;

  // ----------------------------------------------------------------
  // File write, branch and watchdog outputs
  // ----------------------------------------------------------------
  assign fwr_d.we   = to_file;
  assign fwr_d.addr = instr.faddr;
  assign fwr_d.data = step_result;
  assign pcl_d      = do_branch;
  assign pct_d      = do_branch ? branch_target : pct_q;
  assign wclr_d     = do_wdt;
  assign pclr_d     = do_wdt;
  // Set by clear watchdog wins over a same-cycle clearing event
  assign to_d = do_wdt ? 1'b1 : (timeout_event ? 1'b0 : to_q);
  assign pd_d = do_wdt ? 1'b1 : (sleep_event ? 1'b0 : pd_q);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= IDEC_ST_EXEC;
      ready_q <= 1'b1;
      w_q     <= W_RST;
      zero_q  <= ZERO_RST;
      fwr_q   <= '0;
      pcl_q   <= 1'b0;
      pct_q   <= PC_RST;
      slot_q  <= 1'b0;
      wclr_q  <= 1'b0;
      pclr_q  <= 1'b0;
      to_q    <= TO_RST;
      pd_q    <= PD_RST;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      w_q     <= w_d;
      zero_q  <= zero_d;
      fwr_q   <= fwr_d;
      pcl_q   <= pcl_d;
      pct_q   <= pct_d;
      slot_q  <= slot_d;
      wclr_q  <= wclr_d;
      pclr_q  <= pclr_d;
      to_q    <= to_d;
      pd_q    <= pd_d;
    end
  end

  // Ports straight from flops
  assign issue_ready              = ready_q;
  assign w_reg                    = w_q;
  assign zero_flag                = zero_q;
  assign fwrite                   = fwr_q;
  assign pc_load                  = pcl_q;
  assign pc_target                = pct_q;
  assign nop_slot                 = slot_q;
  assign watchdog_counter_clear   = wclr_q;
  assign watchdog_prescaler_clear = pclr_q;
  assign timeout_status_bit       = to_q;
  assign power_down_status_bit    = pd_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Expected values computed independently of the stepper
  wire logic [DATA_W-1:0] dec_expect = file_rdata - STEP_ONE;
  wire logic [DATA_W-1:0] inc_expect = file_rdata + STEP_ONE;

  AST_DEC_TO_W: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_dec && !instr.dest |=>
      (w_reg == $past(dec_expect)) && !fwrite.we)
    else $error("decrement to W gave wrong value");

  AST_CLEAR_W: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_clear_working_op |=> (w_reg == CLEAR_VALUE) && zero_flag)
    else $error("clear W did not zero W and set zero flag");

  AST_SKIP_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    accept && is_skipop |=> (zero_flag == $past(zero_flag)))
    else $error("skip form changed the zero flag");

  AST_SKIP_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    accept && is_skipop && ((op_decsz ? dec_expect : inc_expect) == '0) |=>
      nop_slot && !issue_ready ##1 issue_ready && !nop_slot)
    else $error("zero skip did not squash exactly one cycle");

  AST_NO_SKIP: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_decsz && (dec_expect != '0) |=> issue_ready && !nop_slot)
    else $error("non-zero skip squashed a cycle");

  // Back-to-back clears may hold the pulse high, so the fall is checked per cycle
  AST_WDT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_clear_watchdog_op |=> watchdog_counter_clear && watchdog_prescaler_clear)
    else $error("watchdog clear pulse missing");

  AST_WDT_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
    !(accept && op_clear_watchdog_op) |=> !watchdog_counter_clear && !watchdog_prescaler_clear)
    else $error("watchdog clear pulse without clear watchdog");

  AST_WDT_STATUS: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_clear_watchdog_op |=> timeout_status_bit && power_down_status_bit)
    else $error("clear watchdog did not set status bits");

  AST_BRANCH_PC: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_branch |=> pc_load && (pc_target == $past(branch_target)))
    else $error("branch target wrong");

  AST_BRANCH_TWO: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_branch |=> !issue_ready ##1 issue_ready)
    else $error("branch did not take two cycles");

  AST_INC_TO_F: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_inc && instr.dest |=>
      fwrite.we && (fwrite.data == $past(inc_expect)) && (w_reg == $past(w_reg)))
    else $error("increment to file gave wrong write");

  AST_ZERO_CALC: assert property (@(posedge clock) disable iff (!rst_n)
    accept && op_inc |=> zero_flag == ($past(inc_expect) == '0))
    else $error("zero flag does not match wrapped result");

endmodule : idec_core

// ==== idec_core_bench.sv ====
// Self-checking bench for idec_core: directed boundary cases, then a
// random instruction stream; one queue entry of expected results per issue.
// Assumes the idec_pkg types and the one-cycle registered contract.
`timescale 1ns/1ps

module idec_core_bench
  import idec_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rdy; logic [7:0] w; logic z; idec_fwrite_t fw;
    logic pcl; logic [14:0] pct; logic wd; logic to; logic pd;
  } idec_exp_t;                           // Expected outputs after an issue

  logic               clock, rst_n, issue_valid, timeout_event, sleep_event;
  idec_instr_t        instr;
  logic [7:0]         file_rdata;
  logic [6:0]         latch;
  logic               issue_ready, zero_flag, pc_load, nop_slot, wdc, wpc, tsb, pdb;
  logic [7:0]         w_reg;
  idec_fwrite_t       fwrite;
  logic [14:0]        pc_target;
  idec_exp_t          exp_q[$];           // Notes from driver to monitor
  logic [7:0]         m_w;                // Model working register
  logic               m_z, m_to, m_pd;    // Model status bits
  logic [14:0]        m_pc;               // Model branch target
  logic [15:0]        lfsr_q = 16'hBB5E;  // Random source, fixed seed
  int                 n_errors = 0;
  int                 n_checks = 0;

  idec_core i_idec_core (
    .clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .instr(instr),
    .file_rdata(file_rdata), .program_page_latch(latch),
    .timeout_event(timeout_event), .sleep_event(sleep_event),
    .issue_ready(issue_ready), .w_reg(w_reg), .zero_flag(zero_flag),
    .fwrite(fwrite), .pc_load(pc_load), .pc_target(pc_target), .nop_slot(nop_slot),
    .watchdog_counter_clear(wdc), .watchdog_prescaler_clear(wpc),
    .timeout_status_bit(tsb), .power_down_status_bit(pdb));

  // ----------------------------------------------------------------
  // Clock, random source, compares and closing
  // ----------------------------------------------------------------
  initial clock = 1'b0;
  always #25 clock = ~clock;              // 20 MHz

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk1(input string n, input logic s, input logic e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk1

  task automatic chk8(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk8

  task automatic chk15(input string n, input logic [14:0] s, input logic [14:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk15

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Driver: offer one instruction, note its expected effects
  // ----------------------------------------------------------------
  task automatic issue(input idec_op_t op, input logic [6:0] fa, input logic d,
                       input logic [10:0] k, input logic [7:0] rd, input logic [6:0] lt,
                       input logic ev_to, input logic ev_sl);
    idec_exp_t e;
    logic [7:0] r;
    logic       skip;
    @(posedge clock);
    issue_valid   <= 1'b1;
    instr         <= '{op, fa, d, k};
    file_rdata    <= rd;
    latch         <= lt;
    timeout_event <= ev_to;
    sleep_event   <= ev_sl;
    r    = (op == DECREMENT_FILE_OP || op == DECREMENT_SKIP_ZERO_OP) ? rd - 8'h01 : rd + 8'h01;
    e.fw = {1'b0, fa, 8'h00};             // Address follows the issue even without a write
    skip = 1'b0;
    if (ev_to) m_to = 1'b0;
    if (ev_sl) m_pd = 1'b0;
    case (op)
      DECREMENT_FILE_OP, INCREMENT_FILE_OP: begin
        if (d) e.fw = {1'b1, fa, r};
        else m_w = r;
        m_z = (r == 8'h00);
      end
      DECREMENT_SKIP_ZERO_OP, INCREMENT_SKIP_ZERO_OP: begin
        if (d) e.fw = {1'b1, fa, r};
        else m_w = r;
        skip = (r == 8'h00);
      end
      CLEAR_WORKING_OP: begin m_w = 8'h00; m_z = 1'b1; end
      CLEAR_WATCHDOG_OP: begin m_to = 1'b1; m_pd = 1'b1; end
      ABSOLUTE_BRANCH_OP: begin m_pc = {lt[6:3], k}; skip = 1'b1; end
      default: ;
    endcase
    e.rdy = !skip; e.w = m_w; e.z = m_z; e.pcl = (op == ABSOLUTE_BRANCH_OP);
    e.pct = m_pc; e.wd = (op == CLEAR_WATCHDOG_OP); e.to = m_to; e.pd = m_pd;
    exp_q.push_back(e);
    // Offer a junk instruction into the squashed slot; it must be dropped
    if (skip) begin
      @(posedge clock);
      lfsr_q = lfsr_next(lfsr_q);
      instr         <= '{idec_op_t'(lfsr_q[2:0]), lfsr_q[9:3], lfsr_q[10], lfsr_q[15:5]};
      file_rdata    <= lfsr_q[15:8];
      timeout_event <= 1'b0;
      sleep_event   <= 1'b0;
    end
  endtask : issue

  task automatic do_reset;
    @(posedge clock);
    issue_valid   <= 1'b0;
    timeout_event <= 1'b0;
    sleep_event   <= 1'b0;
    rst_n         <= 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    m_w = W_RST; m_z = ZERO_RST; m_to = TO_RST; m_pd = PD_RST; m_pc = PC_RST;
    #10;
    chk8("w_reg", w_reg, 8'h00);
    chk1("zero_flag", zero_flag, 1'b0);
    chk1("status bits", tsb & pdb, 1'b1);
    chk15("pc_target", pc_target, 15'h0000);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Monitor: compare 10 ns after every accepting edge
  // ----------------------------------------------------------------
  always @(posedge clock) begin : mon
    idec_exp_t e;
    logic      acc;
    acc = (rst_n === 1'b1) && (issue_valid === 1'b1) && (issue_ready === 1'b1);
    #10;
    if (acc && exp_q.size() == 0) begin
      n_errors++;
      $display("BAD queue expected entry seen none");
    end else if (acc) begin
      e = exp_q.pop_front();
      chk1("issue_ready", issue_ready, e.rdy);
      chk1("nop_slot", nop_slot, !e.rdy);
      chk8("w_reg", w_reg, e.w);
      chk1("zero_flag", zero_flag, e.z);
      chk8("fwrite", {fwrite.we, fwrite.addr}, {e.fw.we, e.fw.addr});
      if (e.fw.we) chk8("fwrite.data", fwrite.data, e.fw.data);
      chk1("pc_load", pc_load, e.pcl);
      chk15("pc_target", pc_target, e.pct);
      chk1("watchdog_counter_clear", wdc, e.wd);
      chk1("watchdog_prescaler_clear", wpc, e.wd);
      chk1("timeout_status_bit", tsb, e.to);
      chk1("power_down_status_bit", pdb, e.pd);
    end else begin
      // Dropped or idle cycle: ready back, no pulse of any kind
      chk1("idle outputs", issue_ready & !fwrite.we & !pc_load & !nop_slot, 1'b1);
      chk1("idle clears", !wdc & !wpc, 1'b1);
    end
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("BAD timeout expected end seen none");
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [15:0] a, b;
    rst_n = 1'b0; issue_valid = 1'b0; instr = '0; file_rdata = 8'h00;
    latch = 7'h00; timeout_event = 1'b0; sleep_event = 1'b0;
    do_reset();
    issue(INCREMENT_FILE_OP, 7'h7F, 1'b0, 11'h000, 8'hFF, 7'h00, 1'b0, 1'b0);
    issue(DECREMENT_FILE_OP, 7'h00, 1'b1, 11'h000, 8'h00, 7'h00, 1'b0, 1'b0);
    issue(DECREMENT_SKIP_ZERO_OP, 7'h12, 1'b0, 11'h000, 8'h01, 7'h00, 1'b0, 1'b0);
    issue(INCREMENT_SKIP_ZERO_OP, 7'h7F, 1'b1, 11'h000, 8'hFF, 7'h00, 1'b0, 1'b0);
    issue(INCREMENT_SKIP_ZERO_OP, 7'h05, 1'b0, 11'h000, 8'h05, 7'h00, 1'b0, 1'b0);
    issue(CLEAR_WORKING_OP, 7'h00, 1'b0, 11'h000, 8'h33, 7'h00, 1'b0, 1'b0);
    issue(IDEC_NOP_OP, 7'h00, 1'b0, 11'h000, 8'h00, 7'h00, 1'b1, 1'b1);
    issue(CLEAR_WATCHDOG_OP, 7'h00, 1'b0, 11'h000, 8'h00, 7'h00, 1'b0, 1'b0);
    issue(CLEAR_WATCHDOG_OP, 7'h00, 1'b0, 11'h000, 8'h00, 7'h00, 1'b1, 1'b1);
    issue(ABSOLUTE_BRANCH_OP, 7'h00, 1'b0, 11'h7FF, 8'h00, 7'h78, 1'b0, 1'b0);
    issue(ABSOLUTE_BRANCH_OP, 7'h00, 1'b0, 11'h000, 8'h00, 7'h07, 1'b0, 1'b0);
    issue(DECREMENT_FILE_OP, 7'h40, 1'b0, 11'h000, 8'h01, 7'h00, 1'b0, 1'b0);
    for (int i = 0; i < 300; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      a = lfsr_q;
      lfsr_q = lfsr_next(lfsr_q);
      b = lfsr_q;
      issue(idec_op_t'(a[2:0]), a[9:3], a[10], b[10:0],
            (a[13:12] == 2'b00) ? (b[14] ? 8'hFF : 8'h01) : (b[7:0] ^ a[15:8]),
            b[6:0] ^ a[6:0], a[15:13] == 3'b111, b[15:13] == 3'b111);
    end
    do_reset();
    issue(INCREMENT_FILE_OP, 7'h01, 1'b0, 11'h000, 8'h7F, 7'h00, 1'b0, 1'b0);
    @(posedge clock);
    issue_valid <= 1'b0;
    repeat (3) @(posedge clock);
    chk8("queue left", 8'(exp_q.size()), 8'h00);
    end_of_test();
  end

endmodule : idec_core_bench
